// >>> dv/ieg_front_model.sv
// Purpose: measurement front end and blocking matrix stand-in
// Assumes: bench commands levels on set_meas and set_block
// Notes:   measurements refresh once per processing base
`timescale 1ns/1ps
`default_nettype none
module ieg_front_model
	import ieg_pkg::*;
#(
	parameter int unsigned TICK = TICK_CYC
) (
	input  wire logic      ref_clk,
	input  wire logic      reset_n,
	input  wire ieg_meas_t set_meas,
	input  wire logic      set_block,
	output var  ieg_meas_t meas,
	output var  ieg_line_t line_volts,
	output var  logic      block_in
);
	int unsigned cnt_ff;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff <= 0;
			meas <= '0;
			line_volts <= '0;
			block_in <= 1'b0;
		end else begin
			// block forwarded at once, well ahead of any operate delay
			block_in <= set_block;
			if (cnt_ff == TICK - 1) begin
				cnt_ff <= 0;
				meas <= set_meas;
				line_volts <= {3{set_meas.vpos}};
			end else begin
				cnt_ff <= cnt_ff + 1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> dv/ieg_guard_assertions.sv
// Purpose: port-level checks for the energize guard stage
// Assumes: bound to ieg_energize_guard_stage, one clock domain
// Notes:   start, trip and blocked outputs move only at processing ticks
`timescale 1ns/1ps
`default_nettype none
module ieg_guard_assertions
	import ieg_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic [10:0] reg_addr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_rdata,
	input  wire ieg_meas_t   meas,
	input  wire ieg_line_t   line_volts,
	input  wire logic        start_out,
	input  wire logic        trip_out,
	input  wire logic        blocked_out,
	input  wire logic        evt_valid,
	input  wire ieg_evt_t    evt_data,
	input  wire logic        disp_note
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////
	// sequences and properties
	sequence s_blk_note;
		disp_note && $rose(blocked_out) ##1 !disp_note;
	endsequence
	property p_excl;
		!(start_out && blocked_out);
	endproperty
	property p_st_on;
		evt_valid && evt_data.flags[EV_ST_ON] |-> $rose(start_out);
	endproperty
	property p_tr_off;
		evt_valid && evt_data.flags[EV_TR_OFF] |-> $fell(trip_out);
	endproperty
	property p_bl_on;
		evt_valid && evt_data.flags[EV_BL_ON] |-> $rose(blocked_out);
	endproperty
	property p_disp;
		$rose(blocked_out) |-> s_blk_note;
	endproperty
	property p_pulse;
		evt_valid |=> !evt_valid;
	endproperty
	property p_meas;
		evt_valid |-> evt_data.meas == $past(meas)
			&& evt_data.line == $past(line_volts);
	endproperty
	property p_stat;
		reg_rd && reg_addr == A_STAT |=> reg_rdata[0] == $past(start_out)
			&& reg_rdata[1] == $past(trip_out)
			&& reg_rdata[2] == $past(blocked_out);
	endproperty
	property p_hold;
		$changed(start_out) |=> $stable(start_out)[*8];
	endproperty

	////////////////////////////////////////////////////////////////////
	// assertions
	a_excl: assert property (p_excl)
		else $error("start and blocked high together");
	a_st_on: assert property (p_st_on)
		else $error("start on event without start rising");
	a_tr_off: assert property (p_tr_off)
		else $error("trip off event without trip falling");
	a_bl_on: assert property (p_bl_on)
		else $error("block event without blocked rising");
	a_disp: assert property (p_disp)
		else $error("no single display note on block");
	a_pulse: assert property (p_pulse)
		else $error("event strobe longer than one cycle");
	a_meas: assert property (p_meas)
		else $error("event values differ from sampled inputs");
	a_stat: assert property (p_stat)
		else $error("status read differs from outputs");
	a_hold: assert property (p_hold)
		else $error("start moved between processing ticks");
endmodule

bind ieg_energize_guard_stage ieg_guard_assertions u_ieg_guard_assertions (
	.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas(meas),
	.line_volts(line_volts), .start_out(start_out), .trip_out(trip_out),
	.blocked_out(blocked_out), .evt_valid(evt_valid),
	.evt_data(evt_data), .disp_note(disp_note)
);
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: directed bench for the energize guard stage
// Assumes: tick shortened to 20 cycles, 4-cycle millisecond
// Notes:   far side comes from ieg_front_model
`timescale 1ns/1ps
`default_nettype none
module testbench
	import ieg_pkg::*;
;
	localparam int TK = 20;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [10:0] reg_addr = 11'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	ieg_meas_t   set_meas = {48'h0, 16'h1770};
	logic        set_block = 1'b0;
	ieg_meas_t   meas;
	ieg_line_t   line_volts;
	logic        block_in, start_out, trip_out, blocked_out;
	logic        evt_valid, disp_note;
	ieg_evt_t    evt_data;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          n_off = 0;
	int          k0;
	logic [31:0] gdef [5] = '{32'h1388, 32'h3E8, 32'h5, 32'h32, 32'h0};
	wire  [2:0]  st = {blocked_out, trip_out, start_out};

	always #20 ref_clk = ~ref_clk;

	ieg_front_model #(.TICK(TK)) u_ieg_front_model (.ref_clk(ref_clk),
		.reset_n(reset_n), .set_meas(set_meas), .set_block(set_block),
		.meas(meas), .line_volts(line_volts), .block_in(block_in));
	ieg_energize_guard_stage #(.TICK_CYCLES(TK), .MS_CYCLES(4))
	u_ieg_energize_guard_stage (.ref_clk(ref_clk), .reset_n(reset_n),
		.clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.meas(meas), .line_volts(line_volts), .block_in(block_in),
		.start_out(start_out), .trip_out(trip_out),
		.blocked_out(blocked_out), .evt_valid(evt_valid),
		.evt_data(evt_data), .disp_note(disp_note));

	always @(posedge ref_clk) begin
		if (evt_valid === 1'b1 && |(evt_data.flags & 6'h2A)) n_off++;
	end

	////////////////////////////////////////////////////////////////////
	// tasks
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [10:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [10:0] a, input logic [31:0] e,
		input string nm);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(nm, e, reg_rdata);
	endtask
	task automatic tk(input int n);
		repeat (n * TK) @(posedge ref_clk);
	endtask
	task automatic wt(input int b, input logic v, input int n,
		input string nm);
		int k;
		k = 0;
		while (st[b] !== v && k < n * TK) begin
			@(posedge ref_clk);
			k++;
		end
		#1 chk(nm, {31'h0, v}, {31'h0, st[b]});
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// tests
	initial begin
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(A_CTRL, 32'h3001, "ctrl");
		for (int f = 0; f < 5; f++) begin
			rd(11'h400 + 11'(4 * f), gdef[f], "group0");
		end
		rd(11'h4E0, 32'h1388, "group7");
		rd(11'h7FC, 32'h0, "unmapped");
		wr(11'h404, 32'h2);
		wr(11'h40C, 32'h2);
		wr(11'h410, 32'h3);
		set_meas.vpos <= 16'h03E8;
		tk(1);
		chk("early", 32'h0, {29'h0, st});
		wt(0, 1'b1, 6, "start");
		set_meas <= {16'h000A, 16'h000A, 16'h0003, 16'h03E8};
		tk(6);
		chk("trip", 32'h0, {31'h0, st[1]});
		set_meas.ic <= 16'h000A;
		wt(1, 1'b1, 8, "trip");
		$display("test pickup done");
		set_block <= 1'b1;
		wt(2, 1'b1, 3, "blocked");
		rd(A_STAT, 32'h4, "status");
		rd(A_CNT_ST, 32'h1, "start count");
		rd(A_CNT_TR, 32'h1, "trip count");
		rd(A_CNT_BL, 32'h1, "block count");
		rd(A_RPTR, 32'h33, "records");
		rd(11'h204, 32'h1, "rec0 flags");
		rd(11'h244, 32'h10, "rec2 flags");
		rd(11'h200, 32'h14, "rec0 stamp");
		rd(11'h248, 32'hA, "rec2 ia");
		rd(11'h25C, 32'h3E8, "rec2 sg vca");
		wr(A_CNT_ST, 32'h0);
		rd(A_CNT_ST, 32'h0, "cleared");
		$display("test block done");
		set_meas <= {48'h0, 16'h03E8};
		set_block <= 1'b0;
		wt(0, 1'b1, 3, "restart");
		set_meas.vpos <= 16'h1770;
		tk(1);
		chk("held", 32'h1, {31'h0, st[0]});
		wt(0, 1'b0, 6, "released");
		$display("test release done");
		for (int f = 1; f < 4; f++) begin
			wr(A_CTRL, 32'h3101 | 32'(f << 4));
			tk(2);
			rd(A_STAT, 32'(1 << (f - 1)), "forced");
		end
		wr(A_CTRL, 32'h3001);
		wt(2, 1'b0, 3, "force off");
		set_meas.vpos <= 16'h03E8;
		wr(A_CTRL, 32'h3501);
		wt(2, 1'b1, 8, "sw block");
		wr(A_CTRL, 32'h3001);
		wt(0, 1'b1, 3, "unforced");
		$display("test forcing done");
		wr(A_CTRL, 32'h3005);
		rd(A_CTRL, 32'h3001, "mode locked");
		wr(A_CTRL, 32'h3201);
		wr(A_CTRL, 32'h3205);
		rd(A_CTRL, 32'h3205, "mode off");
		wt(0, 1'b0, 3, "off");
		wr(A_CTRL, 32'h3202);
		wt(2, 1'b1, 8, "mode block");
		k0 = n_off;
		wr(A_CTRL, 32'h1201);
		wt(0, 1'b1, 3, "on only");
		tk(1);
		chk("off events", 32'(k0), 32'(n_off));
		wr(A_CTRL, 32'h3205);
		wt(0, 1'b0, 3, "instant prep");
		set_meas <= {16'h000A, 16'h000A, 16'h000A, 16'h03E8};
		tk(2);
		wr(A_CTRL, 32'h00103201);
		wt(1, 1'b1, 3, "instant");
		rd(11'h364, 32'h5, "instant flags");
		rd(A_RPTR, 32'hC0, "wrapped");
		$display("test modes done");
		results;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		results;
	end
endmodule
`default_nettype wire

// >>> logic/ieg_energize_guard_stage.sv
// Purpose: inadvertent energize guard stage with events and records
// Assumes: measurements synchronous to ref_clk, refreshed every 5 ms
// Notes:   register port reads answer one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none

// Operation
// - blocking input sampled at each cycle start
// - unblocked pick-up raises start, runs operate delay
// - blocked pick-up raises blocked, nothing further
// - late block drops start, release as usual
// - block gives display note and stamped event
// - software switch blocks while forcing enabled
// - outputs start, trip and blocked
// - six on/off event types
// - select on, off or both events
// - events carry stamp and measured values
// - twelve-entry circular record store
// - records only on-transitions, with currents, voltages, group
// - eight setting groups, one common selector
// - instantaneous and time-delayed modes
// - instant mode: start and trip share stamp
// - stamps in one millisecond steps
// - resettable start, trip, blocked counters
// - three phase RMS currents plus positive voltage
// - mode and forcing independent of group
// - mode 1 on to 5 off, gated writes
// - forced status 0..3 while forcing enabled
// - undervoltage start after activation delay
// - start holds for release delay
// - trip when all phase currents exceed limit
// - undervoltage limit in percent, default fifty
module ieg_energize_guard_stage
	import ieg_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC,
	parameter int unsigned MS_CYCLES   = MS_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic [10:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [31:0] reg_rdata,
	input  wire ieg_meas_t   meas,
	input  wire ieg_line_t   line_volts,
	input  wire logic        block_in,
	output var  logic        start_out,
	output var  logic        trip_out,
	output var  logic        blocked_out,
	output var  logic        evt_valid,
	output var  ieg_evt_t    evt_data,
	output var  logic        disp_note
);

	////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] sat_inc(input logic [31:0] v);
		sat_inc = (v == 32'hFFFFFFFF) ? v : v + 32'h00000001;
	endfunction

	function automatic logic [19:0] cnt_inc(input logic [19:0] v);
		cnt_inc = (v == 20'hFFFFF) ? v : v + 20'h00001;
	endfunction

	////////////////////////////////////////////////////////////////////
	// state
	logic [31:0] ctrl_ff;
	logic [31:0] tick_div_ff;
	logic [31:0] ms_div_ff;
	logic        tick_ff;
	logic [31:0] stamp_ff;
	logic [15:0] uv_lim_ff  [N_GROUPS];
	logic [15:0] cur_lim_ff [N_GROUPS];
	logic [19:0] act_dly_ff [N_GROUPS];
	logic [19:0] rel_dly_ff [N_GROUPS];
	logic [19:0] op_dly_ff  [N_GROUPS];
	logic        pk_ff;
	logic [19:0] act_cnt_ff;
	logic [19:0] rel_cnt_ff;
	logic [19:0] op_cnt_ff;
	logic [31:0] cnt_st_ff;
	logic [31:0] cnt_tr_ff;
	logic [31:0] cnt_bl_ff;
	ieg_evt_t    rec_ff     [N_RECS];
	logic [3:0]  rec_ptr_ff;
	logic [3:0]  rec_num_ff;

	////////////////////////////////////////////////////////////////////
	// control decode
	wire ieg_mode_t  mode     = ieg_mode_t'(ctrl_ff[C_MODE +: 3]);
	wire ieg_force_t fsel     = ieg_force_t'(ctrl_ff[C_FSEL +: 2]);
	wire logic       f_en     = ctrl_ff[C_FEN];
	wire logic       m_allow  = ctrl_ff[C_MALLOW];
	wire logic       sw_blk   = ctrl_ff[C_SWBLK];
	wire logic [1:0] esel     = ctrl_ff[C_ESEL +: 2];
	wire logic [2:0] sg       = ctrl_ff[C_SG +: 3];
	wire logic       inst     = ctrl_ff[C_INST];
	wire logic       mode_off = (mode == MODE_OFF);
	wire logic       mode_blk = (mode == MODE_BLK) || (mode == MODE_TSTBLK);

	// register writes
	wire logic       wr_ctrl  = reg_wr && (reg_addr == A_CTRL);
	wire logic       wr_cst   = reg_wr && (reg_addr == A_CNT_ST);
	wire logic       wr_ctr   = reg_wr && (reg_addr == A_CNT_TR);
	wire logic       wr_cbl   = reg_wr && (reg_addr == A_CNT_BL);
	wire logic       wr_grp   = reg_wr && (reg_addr[10:9] == A_GRP_PAGE);
	wire logic [2:0] w_grp    = reg_addr[7:5];
	wire logic [2:0] w_fld    = reg_addr[4:2];
	wire logic [2:0] w_mode   = reg_wdata[C_MODE +: 3];
	wire logic       mode_ok  = m_allow && (w_mode >= 3'(MODE_ON))
		&& (w_mode <= 3'(MODE_OFF));
	wire logic [31:0] nxt_ctrl = {reg_wdata[31:3],
		mode_ok ? w_mode : ctrl_ff[C_MODE +: 3]};

	////////////////////////////////////////////////////////////////////
	// pick-up and timing, evaluated on the processing tick
	wire logic blk_now = block_in || (f_en && sw_blk) || mode_blk;
	wire logic uv      = meas.vpos < uv_lim_ff[sg];
	wire logic oc      = (meas.ia > cur_lim_ff[sg])
		&& (meas.ib > cur_lim_ff[sg]) && (meas.ic > cur_lim_ff[sg]);
	wire logic pk_rise = uv && !pk_ff && (act_cnt_ff >= act_dly_ff[sg]);
	wire logic rel_go  = pk_ff && !uv;
	wire logic pk_fall = rel_go && (rel_cnt_ff >= rel_dly_ff[sg]);
	wire logic nxt_pk  = !mode_off && (pk_rise || (pk_ff && !pk_fall));
	wire logic [19:0] nxt_act = (uv && !pk_ff) ? cnt_inc(act_cnt_ff) : 20'h0;
	wire logic [19:0] nxt_rel = rel_go ? cnt_inc(rel_cnt_ff) : 20'h0;
	wire logic st_c    = nxt_pk && !blk_now;
	wire logic bl_c    = nxt_pk && blk_now;
	wire logic run_op  = st_c && oc;
	wire logic [19:0] nxt_op = run_op ? cnt_inc(op_cnt_ff) : 20'h0;
	wire logic tr_c    = run_op && (inst || op_cnt_ff >= op_dly_ff[sg]);

	// forcing overrides the computed state
	wire logic force_on = f_en && (fsel != FS_NORMAL);
	wire logic nxt_st  = force_on ? (fsel == FS_START) : st_c;
	wire logic nxt_tr  = force_on ? (fsel == FS_TRIP)  : tr_c;
	wire logic nxt_bl  = force_on ? (fsel == FS_BLOCKED) : bl_c;

	// transitions
	wire logic [5:0] flags = {
		blocked_out && !nxt_bl, !blocked_out && nxt_bl,
		trip_out && !nxt_tr,    !trip_out && nxt_tr,
		start_out && !nxt_st,   !start_out && nxt_st};
	wire logic [5:0] on_m  = 6'h15;
	wire logic [5:0] keep  = {3{!esel[1], !esel[0]}} ^ 6'h3F;
	wire logic [5:0] ev_fl = flags & keep;
	wire logic [5:0] on_fl = flags & on_m;
	wire ieg_evt_t   snap  = '{stamp: stamp_ff, flags: ev_fl, sg: sg,
		meas: meas, line: line_volts};
	wire ieg_evt_t   rsnap = '{stamp: stamp_ff, flags: on_fl, sg: sg,
		meas: meas, line: line_volts};
	wire logic       go    = clk_en && tick_ff;

	////////////////////////////////////////////////////////////////////
	// register read mux
	wire logic [3:0] r_idx  = reg_addr[8:5];
	wire logic [2:0] r_fld  = reg_addr[4:2];
	wire logic       r_rec  = (reg_addr[10:9] == A_REC_PAGE)
		&& (r_idx < 4'(N_RECS));
	wire logic       r_grp  = (reg_addr[10:9] == A_GRP_PAGE);
	wire ieg_evt_t   r_ent  = rec_ff[r_idx < 4'(N_RECS) ? r_idx : 4'h0];
	logic [31:0]     rec_word;
	logic [31:0]     grp_word;
	logic [31:0]     rd_mux;

	always_comb begin
		unique case (r_fld)
			3'h0: rec_word = r_ent.stamp;
			3'h1: rec_word = {26'h0, r_ent.flags};
			3'h2: rec_word = {16'h0, r_ent.meas.ia};
			3'h3: rec_word = {16'h0, r_ent.meas.ib};
			3'h4: rec_word = {16'h0, r_ent.meas.ic};
			3'h5: rec_word = {16'h0, r_ent.line.vab};
			3'h6: rec_word = {16'h0, r_ent.line.vbc};
			3'h7: rec_word = {13'h0, r_ent.sg, r_ent.line.vca};
		endcase
		unique case (r_fld)
			G_UV:    grp_word = {16'h0, uv_lim_ff[w_grp]};
			G_ACT:   grp_word = {12'h0, act_dly_ff[w_grp]};
			G_CUR:   grp_word = {16'h0, cur_lim_ff[w_grp]};
			G_REL:   grp_word = {12'h0, rel_dly_ff[w_grp]};
			G_OP:    grp_word = {12'h0, op_dly_ff[w_grp]};
			default: grp_word = 32'h0;
		endcase
		rd_mux = 32'h0;
		if (r_rec) begin
			rd_mux = rec_word;
		end else if (r_grp) begin
			rd_mux = grp_word;
		end else begin
			unique case (reg_addr)
				A_CTRL:   rd_mux = ctrl_ff;
				A_STAT:   rd_mux = {29'h0, blocked_out, trip_out, start_out};
				A_CNT_ST: rd_mux = cnt_st_ff;
				A_CNT_TR: rd_mux = cnt_tr_ff;
				A_CNT_BL: rd_mux = cnt_bl_ff;
				A_TIME:   rd_mux = stamp_ff;
				A_RPTR:   rd_mux = {24'h0, rec_num_ff, rec_ptr_ff};
				default:  rd_mux = 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// time bases
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_div_ff <= 32'h0;
			tick_ff     <= 1'b0;
			ms_div_ff   <= 32'h0;
			stamp_ff    <= 32'h0;
		end else if (clk_en) begin
			tick_ff     <= (tick_div_ff == TICK_CYCLES - 1);
			tick_div_ff <= (tick_div_ff == TICK_CYCLES - 1) ? 32'h0
				: tick_div_ff + 32'h1;
			ms_div_ff   <= (ms_div_ff == MS_CYCLES - 1) ? 32'h0
				: ms_div_ff + 32'h1;
			if (ms_div_ff == MS_CYCLES - 1) begin
				stamp_ff <= stamp_ff + 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// control and group settings
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_ff <= {11'h0, 1'b0, 1'b0, 3'h0, 2'h0, RST_ESEL, 3'h0,
				1'b0, 2'h0, 2'(FS_NORMAL), 1'b0, 3'(MODE_ON)};
		end else if (clk_en && wr_ctrl) begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int g = 0; g < N_GROUPS; g++) begin
				uv_lim_ff[g]  <= RST_UV;
				act_dly_ff[g] <= RST_ACT;
				cur_lim_ff[g] <= RST_CUR;
				rel_dly_ff[g] <= RST_REL;
				op_dly_ff[g]  <= RST_OP;
			end
		end else if (clk_en && wr_grp) begin
			unique case (w_fld)
				G_UV:    uv_lim_ff[w_grp]  <= reg_wdata[15:0];
				G_ACT:   act_dly_ff[w_grp] <= reg_wdata[19:0];
				G_CUR:   cur_lim_ff[w_grp] <= reg_wdata[15:0];
				G_REL:   rel_dly_ff[w_grp] <= reg_wdata[19:0];
				G_OP:    op_dly_ff[w_grp]  <= reg_wdata[19:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// stage evaluation and outputs
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pk_ff       <= 1'b0;
			act_cnt_ff  <= 20'h0;
			rel_cnt_ff  <= 20'h0;
			op_cnt_ff   <= 20'h0;
			start_out   <= 1'b0;
			trip_out    <= 1'b0;
			blocked_out <= 1'b0;
			evt_valid   <= 1'b0;
			evt_data    <= '0;
			disp_note   <= 1'b0;
		end else if (clk_en) begin
			evt_valid <= 1'b0;
			disp_note <= 1'b0;
			if (tick_ff) begin
				pk_ff       <= nxt_pk;
				act_cnt_ff  <= nxt_act;
				rel_cnt_ff  <= nxt_rel;
				op_cnt_ff   <= nxt_op;
				start_out   <= nxt_st;
				trip_out    <= nxt_tr;
				blocked_out <= nxt_bl;
				evt_valid   <= |ev_fl;
				evt_data    <= snap;
				disp_note   <= flags[EV_BL_ON];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// operation records and counters
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int r = 0; r < N_RECS; r++) begin
				rec_ff[r] <= '0;
			end
			rec_ptr_ff <= 4'h0;
			rec_num_ff <= 4'h0;
		end else if (go && |on_fl) begin
			rec_ff[rec_ptr_ff] <= rsnap;
			rec_ptr_ff <= (rec_ptr_ff == 4'(N_RECS - 1)) ? 4'h0
				: rec_ptr_ff + 4'h1;
			if (rec_num_ff != 4'(N_RECS)) begin
				rec_num_ff <= rec_num_ff + 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_st_ff <= 32'h0;
			cnt_tr_ff <= 32'h0;
			cnt_bl_ff <= 32'h0;
		end else if (clk_en) begin
			if (go && flags[EV_ST_ON]) begin
				cnt_st_ff <= wr_cst ? 32'h1 : sat_inc(cnt_st_ff);
			end else if (wr_cst) begin
				cnt_st_ff <= 32'h0;
			end
			if (go && flags[EV_TR_ON]) begin
				cnt_tr_ff <= wr_ctr ? 32'h1 : sat_inc(cnt_tr_ff);
			end else if (wr_ctr) begin
				cnt_tr_ff <= 32'h0;
			end
			if (go && flags[EV_BL_ON]) begin
				cnt_bl_ff <= wr_cbl ? 32'h1 : sat_inc(cnt_bl_ff);
			end else if (wr_cbl) begin
				cnt_bl_ff <= 32'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// read port
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0;
		end else if (clk_en) begin
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
		end
	end

endmodule

`default_nettype wire

// >>> logic/ieg_pkg.sv
// Purpose: shared constants and types for the energize guard stage
// Assumes: 25 MHz ref_clk, 5 ms processing cycle, 1 ms stamp
// Notes:   measurements in 0.01 units of nominal (volts %Un, amps xIn)
package ieg_pkg;

	////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_HZ       = 25_000_000;
	localparam int unsigned BASE_MS      = 5;
	localparam int unsigned STAMP_MS     = 1;
	localparam int unsigned TICK_CYC     = CLK_HZ / 1000 * BASE_MS;
	localparam int unsigned MS_CYC       = CLK_HZ / 1000 * STAMP_MS;
	localparam int unsigned N_GROUPS     = 8;
	localparam int unsigned N_RECS       = 12;

	////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam logic [10:0] A_CTRL       = 11'h000;
	localparam logic [10:0] A_STAT       = 11'h004;
	localparam logic [10:0] A_CNT_ST     = 11'h008;
	localparam logic [10:0] A_CNT_TR     = 11'h00C;
	localparam logic [10:0] A_CNT_BL     = 11'h010;
	localparam logic [10:0] A_TIME       = 11'h014;
	localparam logic [10:0] A_RPTR       = 11'h018;
	localparam logic [1:0]  A_REC_PAGE   = 2'h1;
	localparam logic [1:0]  A_GRP_PAGE   = 2'h2;

	// control fields
	localparam int unsigned C_MODE       = 0;
	localparam int unsigned C_FSEL       = 4;
	localparam int unsigned C_FEN        = 8;
	localparam int unsigned C_MALLOW     = 9;
	localparam int unsigned C_SWBLK      = 10;
	localparam int unsigned C_ESEL       = 12;
	localparam int unsigned C_SG         = 16;
	localparam int unsigned C_INST       = 20;

	// group setting fields (word index within a group)
	localparam logic [2:0]  G_UV         = 3'h0;
	localparam logic [2:0]  G_ACT        = 3'h1;
	localparam logic [2:0]  G_CUR        = 3'h2;
	localparam logic [2:0]  G_REL        = 3'h3;
	localparam logic [2:0]  G_OP         = 3'h4;

	////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [15:0] RST_UV       = 16'h1388;
	localparam logic [19:0] RST_ACT      = 20'h003E8;
	localparam logic [15:0] RST_CUR      = 16'h0005;
	localparam logic [19:0] RST_REL      = 20'h00032;
	localparam logic [19:0] RST_OP       = 20'h00000;
	localparam logic [1:0]  RST_ESEL     = 2'h3;

	// event flag positions
	localparam int unsigned EV_ST_ON     = 0;
	localparam int unsigned EV_ST_OFF    = 1;
	localparam int unsigned EV_TR_ON     = 2;
	localparam int unsigned EV_TR_OFF    = 3;
	localparam int unsigned EV_BL_ON     = 4;
	localparam int unsigned EV_BL_OFF    = 5;

	typedef enum logic [2:0] {
		MODE_ON      = 3'h1,
		MODE_BLK     = 3'h2,
		MODE_TEST    = 3'h3,
		MODE_TSTBLK  = 3'h4,
		MODE_OFF     = 3'h5
	} ieg_mode_t;

	typedef enum logic [1:0] {
		FS_NORMAL    = 2'h0,
		FS_START     = 2'h1,
		FS_TRIP      = 2'h2,
		FS_BLOCKED   = 2'h3
	} ieg_force_t;

	typedef struct packed {
		logic [15:0] ia;
		logic [15:0] ib;
		logic [15:0] ic;
		logic [15:0] vpos;
	} ieg_meas_t;

	typedef struct packed {
		logic [15:0] vab;
		logic [15:0] vbc;
		logic [15:0] vca;
	} ieg_line_t;

	typedef struct packed {
		logic [31:0] stamp;
		logic [5:0]  flags;
		logic [2:0]  sg;
		ieg_meas_t   meas;
		ieg_line_t   line;
	} ieg_evt_t;

endpackage
